// [hdl/sscp_port.sv]
// Subsystem control port with error indicator, rate selects and link activity detection.

module sscp_port (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [sscp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [sscp_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [sscp_pkg::BE_W-1:0] avs_byteenable,
    output logic [sscp_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic downstream_reset_out,
    output logic downstream_analysis_out,
    input wire logic downstream_fault_in_n,
    output logic module_fault_indicator_n,
    output logic module_fault_indicator_oe,
    input wire logic link0_rate_select,
    input wire logic links_1to3_rate_select,
    output logic link0_rate_high,
    output logic links_1to3_rate_high,
    input wire logic [sscp_pkg::LINKS-1:0] serial_link_rx,
    output logic [sscp_pkg::LINKS-1:0] serial_link_rx_level,
    output logic irq
);
    import sscp_pkg::*;

    logic [1:0] rst_pipe_q;
    logic rst_sync_n;
    logic wait_q;
    logic [DATA_W-1:0] rdata_q;
    logic reset_q;
    logic analysis_q;
    logic mod_err_q;
    logic ind_n_q;
    logic [INT_W-1:0] status_q;
    logic [INT_W-1:0] status_d;
    logic [INT_W-1:0] mask_q;
    logic irq_q;
    logic fault_n_lvl;
    logic fault_prev_q;
    logic rate0_lvl;
    logic rate1_lvl;
    logic rate0_q;
    logic rate1_q;
    logic [LINKS-1:0] rx_lvl;
    logic [LINKS-1:0] rx_prev_q;

    // The reset is released through two flops so that every other flop leaves reset on one edge.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_q[1];

    // Pin inputs; the fault input idles high, the link inputs idle low.
    sscp_sync #(.W(1), .RST_VAL(FAULT_N_IDLE)) u_sync_fault (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .pin(downstream_fault_in_n),
        .level(fault_n_lvl)
    );
    sscp_sync #(.W(2), .RST_VAL(2'h0)) u_sync_rate (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .pin({links_1to3_rate_select, link0_rate_select}),
        .level({rate1_lvl, rate0_lvl})
    );
    sscp_sync #(.W(LINKS), .RST_VAL(RX_IDLE)) u_sync_rx (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .pin(serial_link_rx),
        .level(rx_lvl)
    );

    // Bus decode. The subsystem block repeats over positive space, own registers sit in one negative page.
    logic req;
    logic accept;
    logic first;
    logic [3:0] offs;
    logic in_pos;
    logic in_own;
    logic be0;
    logic fault_seen;
    assign req = avs_read | avs_write;
    assign first = req & wait_q;
    assign accept = req & ~wait_q;
    assign offs = avs_address[WIN_LSB-1:0];
    assign in_pos = ~avs_address[ADDR_W-1];
    assign in_own = (avs_address[ADDR_W-1:WIN_LSB] == OWN_PAGE);
    assign be0 = avs_byteenable[0];
    assign fault_seen = ~fault_n_lvl;

    // Write strobes, each taken only at the accepting edge with the low byte enabled.
    logic wr_ok;
    logic wr_reset;
    logic wr_analysis;
    logic wr_status;
    logic wr_mask;
    logic wr_ctrl;
    assign wr_ok = accept & avs_write & be0;
    assign wr_reset = wr_ok & in_pos & (offs == OFF_RESET);
    assign wr_analysis = wr_ok & in_pos & (offs == OFF_ANALYSIS);
    assign wr_status = wr_ok & in_own & (offs == OFF_INT_STATUS);
    assign wr_mask = wr_ok & in_own & (offs == OFF_INT_MASK);
    assign wr_ctrl = wr_ok & in_own & (offs == OFF_CTRL);

    // Read mux; write-only, unused and unmapped locations return zero.
    logic [DATA_W-1:0] info_word;
    logic [DATA_W-1:0] rdata_d;
    assign info_word = {{(DATA_W - INFO_RX_LSB - LINKS){1'b0}}, rx_lvl,
                        rate_of(rate1_q), rate_of(rate0_q)};
    assign rdata_d =
        (in_pos && offs == OFF_ERROR) ? {{(DATA_W-1){1'b0}}, fault_seen} :
        (in_own && offs == OFF_INT_STATUS) ? {{(DATA_W-INT_W){1'b0}}, status_q} :
        (in_own && offs == OFF_INT_MASK) ? {{(DATA_W-INT_W){1'b0}}, mask_q} :
        (in_own && offs == OFF_CTRL) ? {{(DATA_W-1){1'b0}}, mod_err_q} :
        (in_own && offs == OFF_INFO) ? info_word : '0;

    // One wait cycle per request: the data is latched on the first edge, the access completes on the second.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            wait_q <= ~first;
            rdata_q <= first ? rdata_d : rdata_q;
        end
    end

    // Downstream outputs hold their level until the next write to their location.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reset_q <= 1'b0;
            analysis_q <= 1'b0;
        end else begin
            reset_q <= wr_reset ? avs_writedata[BIT_LEVEL] : reset_q;
            analysis_q <= wr_analysis ? avs_writedata[BIT_LEVEL] : analysis_q;
        end
    end

    // The module's own error is a software-set control bit; the pin only ever pulls low.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mod_err_q <= 1'b0;
            ind_n_q <= 1'b0;
        end else begin
            mod_err_q <= wr_ctrl ? avs_writedata[BIT_LEVEL] : mod_err_q;
            ind_n_q <= 1'b0;
        end
    end

    // Events: fault arrival, rising activity on a link input, and any change of a rate select.
    logic [LINKS-1:0] link_evt;
    logic fault_evt;
    logic rate_evt;
    logic [INT_W-1:0] events;
    assign fault_evt = fault_seen & ~fault_prev_q;
    assign link_evt = rx_lvl & ~rx_prev_q;
    assign rate_evt = (rate0_lvl ^ rate0_q) | (rate1_lvl ^ rate1_q);
    assign events = {rate_evt, link_evt, fault_evt};
    // A set in the same cycle as a write-one-to-clear wins, so no event is lost.
    assign status_d = events | (status_q & ~(wr_status ? avs_writedata[INT_W-1:0] : '0));

    // Sticky status, mask and the registered interrupt level.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            status_q <= '0;
            mask_q <= INT_MASK_RST;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q <= wr_mask ? avs_writedata[INT_W-1:0] : mask_q;
            irq_q <= |(status_q & mask_q);
        end
    end

    // Edge history and registered copies of the synchronised levels.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fault_prev_q <= 1'b0;
            rx_prev_q <= RX_IDLE;
            rate0_q <= 1'b0;
            rate1_q <= 1'b0;
        end else begin
            fault_prev_q <= fault_seen;
            rx_prev_q <= rx_lvl;
            rate0_q <= rate0_lvl;
            rate1_q <= rate1_lvl;
        end
    end

    // Every output comes straight from a flop.
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign downstream_reset_out = reset_q;
    assign downstream_analysis_out = analysis_q;
    assign module_fault_indicator_n = ind_n_q;
    assign module_fault_indicator_oe = mod_err_q;
    assign link0_rate_high = rate0_q;
    assign links_1to3_rate_high = rate1_q;
    assign serial_link_rx_level = rx_prev_q;
    assign irq = irq_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_sync_n);

    // A request is answered after exactly one wait cycle.
    sequence s_req_new;
        req && wait_q;
    endsequence
    sequence s_answer;
        !wait_q && req;
    endsequence
    property p_wait_one;
        s_req_new |=> s_answer ##1 wait_q;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("request not answered after one wait cycle");

    // A reset write drives the output to bit 0 of the data on the next cycle.
    property p_reset_wr;
        wr_reset |=> downstream_reset_out == $past(avs_writedata[BIT_LEVEL]);
    endproperty
    a_reset_wr: assert property (p_reset_wr) else $error("reset output did not follow write");

    // An analysis write at any sixteen-byte alias drives the analysis output.
    property p_analysis_wr;
        accept && avs_write && be0 && !avs_address[ADDR_W-1] && avs_address[WIN_LSB-1:0] == OFF_ANALYSIS
            |=> downstream_analysis_out == $past(avs_writedata[BIT_LEVEL]);
    endproperty
    a_analysis_wr: assert property (p_analysis_wr) else $error("analysis output did not follow write");

    // Without a reset write the output level is held.
    property p_reset_hold;
        !wr_reset |=> $stable(downstream_reset_out);
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset output changed without a write");

    // A read of the error location returns the synchronised fault in bit 0.
    property p_err_read;
        (s_req_new and (avs_read && in_pos && offs == OFF_ERROR))
            |=> avs_readdata[BIT_LEVEL] == $past(fault_seen);
    endproperty
    a_err_read: assert property (p_err_read) else $error("error read does not show fault");

    // Unused offsets read as zero.
    property p_unused_read;
        (s_req_new and (avs_read && in_pos && (offs == OFF_UNUSED_A || offs == OFF_UNUSED_B)))
            |=> avs_readdata == '0;
    endproperty
    a_unused_read: assert property (p_unused_read) else $error("unused offset read nonzero");

    // A fault held low for four samples of a running synchroniser shows as set; samples taken in reset don't count.
    property p_fault_sync;
        (!downstream_fault_in_n && rst_sync_n)[*4] |=> fault_seen;
    endproperty
    a_fault_sync: assert property (p_fault_sync) else $error("fault not seen after synchroniser");

    // A released fault input held high for four samples clears the error bit again.
    property p_fault_clear;
        (downstream_fault_in_n && rst_sync_n)[*4] |=> !fault_seen;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault still seen after release");

    // The indicator pulls low exactly when the control bit was written set.
    property p_indicator;
        wr_ctrl |=> module_fault_indicator_oe == $past(avs_writedata[BIT_LEVEL]) && !module_fault_indicator_n;
    endproperty
    a_indicator: assert property (p_indicator) else $error("fault indicator wrong after control write");

    // A high rate select held for five samples of a running synchroniser selects the high rate.
    // Samples taken while the synchroniser is still held in reset would otherwise fire it after a mid-run reset.
    property p_rate;
        (link0_rate_select && rst_sync_n)[*5] |=> link0_rate_high && info_word[RATE_W-1:0] == RATE_HIGH_MBPS;
    endproperty
    a_rate: assert property (p_rate) else $error("link 0 rate not high");

    // Idle link inputs raise no link events.
    property p_rx_idle;
        (serial_link_rx == RX_IDLE)[*5] |=> link_evt == RX_IDLE;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("idle link raised activity");

    // The interrupt follows the masked status one cycle later.
    property p_irq;
        ##1 irq == $past(|(status_q & mask_q));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level mismatch");

    // A fault arrival sets its status bit even when a clear of that bit lands in the same cycle.
    property p_fault_event;
        fault_evt |=> status_q[INT_FAULT];
    endproperty
    a_fault_event: assert property (p_fault_event) else $error("fault arrival did not set status");

endmodule // sscp_port

// [hdl/sscp_pkg.sv]
// Package of constants shared by the subsystem control port and its synchroniser.
package sscp_pkg;

    // Bus and pin widths.
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W = 4;
    localparam int unsigned LINKS = 4;
    localparam int unsigned RATE_W = 8;

    // Offsets inside the sixteen-byte block that repeats over positive space.
    localparam int unsigned WIN_LSB = 4;
    localparam logic [3:0] OFF_RESET = 4'h0;
    localparam logic [3:0] OFF_ANALYSIS = 4'h4;
    localparam logic [3:0] OFF_ERROR = 4'h0;
    localparam logic [3:0] OFF_UNUSED_A = 4'h8;
    localparam logic [3:0] OFF_UNUSED_B = 4'hC;

    // Page of the block's own registers, placed in negative space.
    localparam logic [27:0] OWN_PAGE = 28'h8000000;
    localparam logic [3:0] OFF_INT_STATUS = 4'h0;
    localparam logic [3:0] OFF_INT_MASK = 4'h4;
    localparam logic [3:0] OFF_CTRL = 4'h8;
    localparam logic [3:0] OFF_INFO = 4'hC;

    // Field positions.
    localparam int unsigned BIT_LEVEL = 0;
    localparam int unsigned INT_FAULT = 0;
    localparam int unsigned INT_LINK_LSB = 1;
    localparam int unsigned INT_RATE = 5;
    localparam int unsigned INT_W = 6;
    localparam int unsigned INFO_RATE1_LSB = 8;
    localparam int unsigned INFO_RX_LSB = 16;

    // Reset values.
    localparam logic [INT_W-1:0] INT_MASK_RST = 6'h00;
    localparam logic [LINKS-1:0] RX_IDLE = 4'h0;
    localparam logic FAULT_N_IDLE = 1'b1;

    // Link rates in Mbit/s for a low and a high select input.
    localparam logic [RATE_W-1:0] RATE_LOW_MBPS = 8'h0A;
    localparam logic [RATE_W-1:0] RATE_HIGH_MBPS = 8'h14;

    // Rate that a select level chooses.
    function automatic logic [RATE_W-1:0] rate_of(input logic sel);
        return sel ? RATE_HIGH_MBPS : RATE_LOW_MBPS;
    endfunction

endpackage

// [hdl/sscp_sync.sv]
// Three-stage pin synchroniser whose output moves once stages two and three agree.
module sscp_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk,
    input wire logic rst_sync_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    import sscp_pkg::*;

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] agree;
    logic [W-1:0] level_d;

    // The first stage feeds only the second; the agreement check looks at two and three.
    assign agree = ~(s2_q ^ s3_q);
    assign level_d = (agree & s2_q) | (~agree & level_q);
    assign level = level_q;

    // Shift the pin through three stages.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            level_q <= RST_VAL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

endmodule // sscp_sync

// [verif/sscp_downstream.sv]
// Model of the downstream subsystem that the port resets and watches.
module sscp_downstream (
    input wire logic sub_reset,
    input wire logic fault_cmd,
    output logic fault_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic err = 1'b0;
    // A real module keeps its error latched until it is reset, so the bench cannot clear it by itself.
    always @(sub_reset or fault_cmd) begin
        if (sub_reset) begin
            err = 1'b0;
        end else if (fault_cmd) begin
            err = 1'b1;
        end
    end
    // The fault line is active low.
    assign fault_n = ~err;
endmodule // sscp_downstream

// [verif/sscp_port_test.sv]
// Self-checking bench for the subsystem control port.
module sscp_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sscp_pkg::*;
    logic mclk, rst_n, avs_read, avs_write, downstream_fault_in_n, flt_cmd;
    logic link0_rate_select, links_1to3_rate_select, avs_waitrequest, irq, fault_wire;
    logic downstream_reset_out, downstream_analysis_out, module_fault_indicator_n, module_fault_indicator_oe;
    logic link0_rate_high, links_1to3_rate_high;
    logic [31:0] avs_address, avs_writedata, avs_readdata, rdat;
    logic [3:0] avs_byteenable, serial_link_rx, serial_link_rx_level;
    int fail_count = 0;
    int num_checks = 0;
    typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [3:0] b; logic [31:0] q; logic r; logic an;} sscp_row_t;
    // Each row: write flag, address, data, byte enables, read result, reset and analysis levels after it.
    sscp_row_t rows [9] = '{
        '{1'b1, 32'h00000000, 32'h00000001, 4'hF, 32'h0, 1'b1, 1'b0},
        '{1'b1, 32'h00000014, 32'h00000001, 4'hF, 32'h0, 1'b1, 1'b1},
        '{1'b1, 32'h00000008, 32'h00000000, 4'hF, 32'h0, 1'b1, 1'b1},
        '{1'b1, 32'h0000000C, 32'h00000000, 4'hF, 32'h0, 1'b1, 1'b1},
        '{1'b1, 32'h00000020, 32'h00000000, 4'hE, 32'h0, 1'b1, 1'b1},
        '{1'b1, 32'h7FFFFFF0, 32'hFFFFFFFE, 4'hF, 32'h0, 1'b0, 1'b1},
        '{1'b0, 32'h00000004, 32'h00000000, 4'hF, 32'h0, 1'b0, 1'b1},
        '{1'b0, 32'h0000000C, 32'h00000000, 4'hF, 32'h0, 1'b0, 1'b1},
        '{1'b1, 32'h00000004, 32'h00000000, 4'hF, 32'h0, 1'b0, 1'b0}};

    sscp_port DUT (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .downstream_reset_out, .downstream_analysis_out,
        .downstream_fault_in_n, .module_fault_indicator_n, .module_fault_indicator_oe, .link0_rate_select,
        .links_1to3_rate_select, .link0_rate_high, .links_1to3_rate_high, .serial_link_rx,
        .serial_link_rx_level, .irq);
    sscp_downstream PEER (.sub_reset(downstream_reset_out), .fault_cmd(flt_cmd), .fault_n(downstream_fault_in_n));
    // The indicator pin has a pull-up, so it reads high whenever nobody pulls it down.
    assign fault_wire = module_fault_indicator_oe ? module_fault_indicator_n : 1'b1;

    // Free-running system clock.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic s);
        chk_word(nm, {31'h0, e}, {31'h0, s});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One bus cycle; the request stands until waitrequest is sampled low, bounded so a hang is reported.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        avs_byteenable <= b;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) chk_bit("waitrequest", 1'b0, avs_waitrequest);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
        cyc(2);
    endtask

    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        chk_word(nm, e, rdat);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 160 cycles the sequence needs.
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        stop_test();
    end

    initial begin
        rst_n <= 1'b0;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= 32'h0;
        avs_writedata <= 32'h0;
        avs_byteenable <= 4'hF;
        flt_cmd <= 1'b0;
        link0_rate_select <= 1'b0;
        links_1to3_rate_select <= 1'b0;
        serial_link_rx <= 4'h0;
        cyc(12);
        chk_bit("waitrequest", 1'b1, avs_waitrequest);
        chk_bit("reset out", 1'b0, downstream_reset_out);
        chk_bit("fault pin", 1'b1, fault_wire);
        rst_n <= 1'b1;
        cyc(5);
        chk_word("rx level", 32'h0, {28'h0, serial_link_rx_level});
        chk_bit("link0 rate", 1'b0, link0_rate_high);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d, rows[i].b);
            if (!rows[i].w) chk_word("readdata", rows[i].q, rdat);
            cyc(1);
            chk_bit("reset out", rows[i].r, downstream_reset_out);
            chk_bit("analysis out", rows[i].an, downstream_analysis_out);
        end
        rd("error idle", 32'h00000000, 32'h0);
        rd("mask", 32'h80000004, 32'h0);
        rd("unmapped", 32'h90000000, 32'h0);
        // Fault arrives, is latched by the far side and shows in the error read and the status.
        flt_cmd <= 1'b1;
        cyc(8);
        flt_cmd <= 1'b0;
        rd("error", 32'h00000000, 32'h1);
        rd("error alias", 32'h7FFFFFF0, 32'h1);
        rd("status", 32'h80000000, 32'h1);
        chk_bit("irq masked", 1'b0, irq);
        wr(32'h80000004, 32'h1);
        chk_bit("irq", 1'b1, irq);
        wr(32'h80000000, 32'h1);
        chk_bit("irq cleared", 1'b0, irq);
        rd("status", 32'h80000000, 32'h0);
        // Only a downstream reset clears the far side's error.
        wr(32'h00000000, 32'h1);
        chk_bit("reset out", 1'b1, downstream_reset_out);
        wr(32'h00000000, 32'h0);
        cyc(6);
        rd("error gone", 32'h00000000, 32'h0);
        // Rate selects, low gives 10 and high gives 20 Mbit/s.
        link0_rate_select <= 1'b1;
        cyc(8);
        chk_bit("link0 rate", 1'b1, link0_rate_high);
        chk_bit("links rate", 1'b0, links_1to3_rate_high);
        rd("info", 32'h8000000C, 32'h00000A14);
        links_1to3_rate_select <= 1'b1;
        serial_link_rx <= 4'h4;
        cyc(8);
        chk_bit("links rate", 1'b1, links_1to3_rate_high);
        chk_word("rx level", 32'h4, {28'h0, serial_link_rx_level});
        rd("info", 32'h8000000C, 32'h00041414);
        rd("status", 32'h80000000, 32'h28);
        // Module error pulls the shared indicator low, then releases it.
        wr(32'h80000008, 32'h1);
        chk_bit("fault pin", 1'b0, fault_wire);
        wr(32'h80000008, 32'h0);
        chk_bit("fault pin", 1'b1, fault_wire);
        // Reset in mid-run drops every output to its idle level.
        wr(32'h00000004, 32'h1);
        rst_n <= 1'b0;
        cyc(3);
        chk_bit("analysis out", 1'b0, downstream_analysis_out);
        chk_bit("irq", 1'b0, irq);
        rst_n <= 1'b1;
        cyc(5);
        rd("mask", 32'h80000004, 32'h0);
        stop_test();
    end
endmodule // sscp_port_test
